//--- src/acd_top.sv
// top of the comparator and threshold dac control block
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
// Notes on behaviour
// RULE1 - disabled comparator status reads zero
// RULE2 - polarity bit one inverts comparator output
// RULE3 - comparator A threshold: level zero or one
// RULE4 - comparators B-D: level zero or external
// RULE5 - status toggle while enabled sets sticky flag
// RULE6 - request needs enable and flag both set
// RULE7 - both edges trigger the edge detector
// RULE8 - status low nibble writes filter enables
// RULE9 - status reads live outputs and flags
// RULE10 - software waits 20us after enabling
// RULE11 - level zero register drives first dac
// RULE12 - level one drives second dac, output
// RULE13 - software zeroes unused dac codes
// RULE14 - buffer enable bit switches output buffer
// RULE15 - reset clears all registers to zero
// RULE16 - comparator outputs pass two flip-flops
// RULE17 - filter needs sixteen stable cycles
// RULE18 - enabled requests ORed into one irq; the code also gates each request with its irq_mask bit, which resets to zero
module acd_top #(
  parameter int NUM_CMP = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [NUM_CMP-1:0] i_cmp_raw,
  output logic [NUM_CMP-1:0] o_cmp_power_en,
  output logic [NUM_CMP-1:0] o_cmp_threshold_select,
  output logic [7:0] o_threshold_level_zero,
  output logic [7:0] o_threshold_level_one,
  output logic o_output_buffer_enable,
  output logic [6:0] o_dac_misc_cfg,
  output logic o_irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] ab_cfg;
    logic [7:0] cd_cfg;
    logic [7:0] vth_zero;
    logic [7:0] vth_one;
    logic [7:0] dac_cfg;
    logic [3:0] filter_en;
    logic [3:0] edge_flag;
    logic [3:0] irq_mask;
    logic [3:0] live_prev;
    logic [7:0] rdata;
    logic irq;
  } acd_top_state_t;

  acd_top_state_t state;
  acd_top_state_t next_state;
  acd_pkg::acd_bus_req_t req;
  logic [3:0] synced;
  logic [3:0] live;
  logic [3:0] cmp_en;
  logic [3:0] irq_en;
  logic [3:0] pol;
  logic [3:0] thsel;
  logic [3:0] edge_seen;
  logic [3:0] flag_clear;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // unpack config nibbles: A high of ab, B low of ab, C high of cd, D low
  assign cmp_en = {state.cd_cfg[acd_pkg::POS_ENABLE], state.cd_cfg[4 + acd_pkg::POS_ENABLE],
    state.ab_cfg[acd_pkg::POS_ENABLE], state.ab_cfg[4 + acd_pkg::POS_ENABLE]};
  assign irq_en = {state.cd_cfg[acd_pkg::POS_IRQ_EN], state.cd_cfg[4 + acd_pkg::POS_IRQ_EN],
    state.ab_cfg[acd_pkg::POS_IRQ_EN], state.ab_cfg[4 + acd_pkg::POS_IRQ_EN]};
  assign pol = {state.cd_cfg[acd_pkg::POS_POLARITY], state.cd_cfg[4 + acd_pkg::POS_POLARITY],
    state.ab_cfg[acd_pkg::POS_POLARITY], state.ab_cfg[4 + acd_pkg::POS_POLARITY]};
  assign thsel = {state.cd_cfg[acd_pkg::POS_THSEL], state.cd_cfg[4 + acd_pkg::POS_THSEL],
    state.ab_cfg[acd_pkg::POS_THSEL], state.ab_cfg[4 + acd_pkg::POS_THSEL]};

  // ****************************************
  // comparator channels
  // ****************************************
  acd_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(i_cmp_raw[3:0]),
    .o_sync(synced)
  ); // RULE16

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_chan
      acd_chan u_chan (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_sync(synced[gi]),
        .i_cfg('{enable: cmp_en[gi], polarity: pol[gi], filter_en: state.filter_en[gi]}),
        .o_live(live[gi])
      );
    end
  endgenerate

  // any change either way, only while enabled
  assign edge_seen = (live ^ state.live_prev) & cmp_en; // RULE5 RULE7

  // write one to a flag bit clears it
  assign flag_clear = (req.wr && req.addr == acd_pkg::ADDR_STATUS) ? req.wdata[7:4] : 4'h0;

  // ****************************************
  // register file and flags
  // ****************************************
  always_comb begin
    next_state = state;
    next_state.live_prev = live;
    // set wins over clear
    next_state.edge_flag = (state.edge_flag & ~flag_clear) | edge_seen; // RULE5
    if (req.wr) begin
      if (req.addr == acd_pkg::ADDR_AB_CFG) begin
        next_state.ab_cfg = req.wdata;
      end else if (req.addr == acd_pkg::ADDR_CD_CFG) begin
        next_state.cd_cfg = req.wdata;
      end else if (req.addr == acd_pkg::ADDR_VTH_ZERO) begin
        next_state.vth_zero = req.wdata; // RULE11
      end else if (req.addr == acd_pkg::ADDR_VTH_ONE) begin
        next_state.vth_one = req.wdata; // RULE12
      end else if (req.addr == acd_pkg::ADDR_DAC_CFG) begin
        next_state.dac_cfg = req.wdata;
      end else if (req.addr == acd_pkg::ADDR_STATUS) begin
        next_state.filter_en = req.wdata[3:0]; // RULE8
      end else if (req.addr == acd_pkg::ADDR_IRQ_MASK) begin
        next_state.irq_mask = req.wdata[3:0];
      end
    end
    // read data valid only the cycle after a read strobe
    next_state.rdata = 8'h00;
    if (req.rd) begin
      if (req.addr == acd_pkg::ADDR_AB_CFG) begin
        next_state.rdata = state.ab_cfg;
      end else if (req.addr == acd_pkg::ADDR_CD_CFG) begin
        next_state.rdata = state.cd_cfg;
      end else if (req.addr == acd_pkg::ADDR_VTH_ZERO) begin
        next_state.rdata = state.vth_zero;
      end else if (req.addr == acd_pkg::ADDR_VTH_ONE) begin
        next_state.rdata = state.vth_one;
      end else if (req.addr == acd_pkg::ADDR_DAC_CFG) begin
        next_state.rdata = state.dac_cfg;
      end else if (req.addr == acd_pkg::ADDR_STATUS) begin
        next_state.rdata = {state.edge_flag, live}; // RULE9
      end else if (req.addr == acd_pkg::ADDR_IRQ_MASK) begin
        next_state.rdata = {4'h0, state.irq_mask};
      end
    end
    // interrupt: enabled flag, gated by mask, ORed
    next_state.irq = |(next_state.edge_flag & irq_en & state.irq_mask); // RULE6 RULE18
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state <= '0; // RULE15
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_rdata = state.rdata;
  assign o_cmp_power_en = cmp_en;
  // A: 0 level zero, 1 level one; B-D: 0 level zero, 1 external
  assign o_cmp_threshold_select = thsel; // RULE3 RULE4
  assign o_threshold_level_zero = state.vth_zero; // RULE11
  assign o_threshold_level_one = state.vth_one; // RULE12
  assign o_output_buffer_enable = state.dac_cfg[acd_pkg::POS_BUF_EN]; // RULE14
  assign o_dac_misc_cfg = state.dac_cfg[6:0];
  assign o_irq = state.irq;

  // ****************************************
  // checks
  // ****************************************
  a_flag_on_edge: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (cmp_en[0] && $changed(live[0])) |=> state.edge_flag[0]) // RULE5
    else $error("edge on comparator A did not set its flag");
  a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state.edge_flag[1] && !flag_clear[1]) |=> state.edge_flag[1]) // RULE5
    else $error("flag B dropped without a clear");
  a_irq_cause: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    o_irq |-> $past(|(next_state.edge_flag & irq_en & state.irq_mask))) // RULE6
    else $error("interrupt without enabled flag");
  a_irq_any: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (state.edge_flag[3] && irq_en[3] && state.irq_mask[3] && !flag_clear[3]) |=> o_irq) // RULE18
    else $error("flag D did not raise interrupt");
  a_status_read: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (req.rd && req.addr == acd_pkg::ADDR_STATUS) |=> o_rdata == {$past(state.edge_flag), $past(live)}) // RULE9
    else $error("status read wrong");
  a_filter_write: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (req.wr && req.addr == acd_pkg::ADDR_STATUS) |=> state.filter_en == $past(req.wdata[3:0])) // RULE8
    else $error("filter enable not stored");
  a_buffer_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    (req.wr && req.addr == acd_pkg::ADDR_DAC_CFG) |=> o_output_buffer_enable == $past(req.wdata[7])) // RULE14
    else $error("buffer enable mismatch");
  a_reset_clear: assert property (@(posedge i_sys_clk)
    !i_rstn |=> (o_threshold_level_one == 8'h00 && o_cmp_power_en == 4'h0 && !o_irq)) // RULE15
    else $error("reset did not clear registers");
endmodule : acd_top

//--- src/acd_pkg.sv
// package for the comparator and threshold dac control block
package acd_pkg;
  // register offsets
  localparam logic [15:0] ADDR_AB_CFG = 16'ha038;
  localparam logic [15:0] ADDR_CD_CFG = 16'ha039;
  localparam logic [15:0] ADDR_VTH_ZERO = 16'ha03a;
  localparam logic [15:0] ADDR_VTH_ONE = 16'ha03b;
  localparam logic [15:0] ADDR_DAC_CFG = 16'ha03c;
  localparam logic [15:0] ADDR_STATUS = 16'ha03d;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'ha03e;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // field positions inside one comparator nibble of a config register
  localparam int POS_ENABLE = 3;
  localparam int POS_THSEL = 2;
  localparam int POS_IRQ_EN = 1;
  localparam int POS_POLARITY = 0;
  // dac config register fields
  localparam int POS_BUF_EN = 7;
  // timing
  localparam int FILTER_CYCLES = 16;
  localparam int FILTER_CNT_W = 5;
  localparam int SYS_CLK_MHZ = 125;
  localparam int SETTLE_US = 20;
  localparam int SETTLE_CYCLES = SETTLE_US * SYS_CLK_MHZ;

  // per comparator configuration carried to a channel
  typedef struct packed {
    logic enable;
    logic polarity;
    logic filter_en;
  } acd_chan_cfg_t;

  // register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acd_bus_req_t;
endpackage : acd_pkg

//--- src/acd_sync.sv
// two flop synchroniser for the four comparator outputs
`timescale 1ns/1ns
module acd_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } acd_sync_state_t;

  acd_sync_state_t state;
  acd_sync_state_t next_state;

  // first stage only feeds the second
  always_comb begin
    next_state.meta = i_async;
    next_state.stable = state.meta;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_sync = state.stable;
endmodule : acd_sync

//--- src/acd_chan.sv
// one comparator channel: polarity, gating, digital filter
`timescale 1ns/1ns
module acd_chan #(
  parameter int FILT_LEN = acd_pkg::FILTER_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_sync,
  input wire acd_pkg::acd_chan_cfg_t i_cfg,
  output logic o_live
);
  typedef struct packed {
    logic filt;
    logic [acd_pkg::FILTER_CNT_W-1:0] cnt;
  } acd_chan_state_t;

  acd_chan_state_t state;
  acd_chan_state_t next_state;
  logic sensed;

  // polarity applied ahead of filter and edge logic
  assign sensed = i_sync ^ i_cfg.polarity; // RULE2

  // filter accepts a new level only after it holds for the full span
  always_comb begin
    next_state = state;
    if (!i_cfg.filter_en || sensed == state.filt) begin
      next_state.filt = sensed;
      next_state.cnt = '0;
    end else if (state.cnt == acd_pkg::FILTER_CNT_W'(FILT_LEN - 1)) begin
      next_state.filt = sensed; // RULE8 RULE17
      next_state.cnt = '0;
    end else begin
      next_state.cnt = state.cnt + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // disabled comparator reads low
  assign o_live = i_cfg.enable & state.filt; // RULE1

  a_filter_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    ($past(i_cfg.filter_en) && $changed(state.filt)) |->
    $past(state.cnt) == acd_pkg::FILTER_CNT_W'(FILT_LEN - 1)) // RULE17
    else $error("filtered level changed before sixteen stable cycles");
  a_disabled_low: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
    !i_cfg.enable |-> !o_live) // RULE1
    else $error("disabled comparator reports high");
endmodule : acd_chan

//--- tb/acd_analog_model.sv
// behavioural model of the four comparators and their threshold dacs
`timescale 1ns/1ns
module acd_analog_model (
  input wire logic [3:0] i_thsel,
  input wire logic [7:0] i_level_zero,
  input wire logic [7:0] i_level_one,
  input wire logic [3:0][7:0] i_analog,
  input wire logic [7:0] i_ext_level,
  output logic [3:0] o_raw
);
  // unpowered comparators still swing, so the block has to gate them
  always_comb begin
    o_raw[0] = i_analog[0] > (i_thsel[0] ? i_level_one : i_level_zero);
    for (int k = 1; k < 4; k++) begin
      o_raw[k] = i_analog[k] > (i_thsel[k] ? i_ext_level : i_level_zero);
    end
  end
endmodule : acd_analog_model

//--- tb/testbench.sv
// self-checking bench for the comparator and dac control block
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic rstn, wr_s, rd_s, rd_q = 1'b0;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, lvl0, lvl1, ext, misc_hi;
  logic [6:0] misc;
  logic [3:0] raw, pwr, thsel;
  logic [3:0][7:0] ain;
  logic buf_en, irq;
  logic [31:0] seed = 32'h73ea;
  logic [31:0] v;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int n_tests = 0;

  // 125 MHz clock
  always #4 clk = ~clk;

  acd_top i_acd_top (.i_sys_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_cmp_raw(raw), .o_cmp_power_en(pwr),
    .o_cmp_threshold_select(thsel), .o_threshold_level_zero(lvl0),
    .o_threshold_level_one(lvl1), .o_output_buffer_enable(buf_en),
    .o_dac_misc_cfg(misc), .o_irq(irq));
  acd_analog_model i_acd_analog_model (.i_thsel(thsel), .i_level_zero(lvl0),
    .i_level_one(lvl1), .i_analog(ain), .i_ext_level(ext), .o_raw(raw));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task check(input logic [7:0] seen, input logic [7:0] want);
    n_tests++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  task results;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results

  // bus cycles; strobes are held between back to back cycles
  task wr(input logic [15:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    rd_s <= 1'b0;
    @(posedge clk);
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    addr <= a;
    wr_s <= 1'b0;
    rd_s <= 1'b1;
    @(posedge clk);
  endtask : rd

  task cyc(input int n);
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : cyc

  // read data stands only in the cycle after the read strobe
  always @(posedge clk) begin
    if (rd_q) check(rdata, exp_q.pop_front());
    rd_q <= rd_s;
  end

  // watchdog
  initial begin
    repeat (10000) @(posedge clk);
    miscompares++;
    results();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    ain = '0;
    ext = 8'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int a = 0; a < 8; a++) rd(acd_pkg::ADDR_AB_CFG + 16'(a), 8'h00);
    for (int n = 0; n < 6; n++) begin
      v = rnd();
      misc_hi = v[15:8] ^ v[7:0];
      ain <= rnd();
      wr(acd_pkg::ADDR_AB_CFG, v[7:0]);
      wr(acd_pkg::ADDR_CD_CFG, v[15:8]);
      wr(acd_pkg::ADDR_VTH_ZERO, v[23:16]);
      wr(acd_pkg::ADDR_VTH_ONE, v[31:24]);
      wr(acd_pkg::ADDR_DAC_CFG, misc_hi);
      cyc(2);
      check({4'h0, pwr}, {4'h0, v[11], v[15], v[3], v[7]});
      check({4'h0, thsel}, {4'h0, v[10], v[14], v[2], v[6]});
      check(lvl0, v[23:16]);
      check(lvl1, v[31:24]);
      check({buf_en, misc}, misc_hi);
      rd(acd_pkg::ADDR_AB_CFG, v[7:0]);
      rd(acd_pkg::ADDR_DAC_CFG, misc_hi);
    end
    ain <= '0;
    wr(acd_pkg::ADDR_VTH_ZERO, 8'h80);
    wr(acd_pkg::ADDR_IRQ_MASK, 8'h0f);
    wr(acd_pkg::ADDR_AB_CFG, 8'haa);
    wr(acd_pkg::ADDR_CD_CFG, 8'haa);
    cyc(acd_pkg::SETTLE_CYCLES);
    wr(acd_pkg::ADDR_STATUS, 8'hf0);
    cyc(2);
    rd(acd_pkg::ADDR_STATUS, 8'h00);
    ain[0] <= 8'hff;
    cyc(8);
    check({7'h00, irq}, 8'h01);
    rd(acd_pkg::ADDR_STATUS, 8'h11);
    ain[0] <= 8'h00;
    cyc(8);
    rd(acd_pkg::ADDR_STATUS, 8'h10);
    wr(acd_pkg::ADDR_IRQ_MASK, 8'h00);
    cyc(3);
    check({7'h00, irq}, 8'h00);
    wr(acd_pkg::ADDR_IRQ_MASK, 8'h0f);
    wr(acd_pkg::ADDR_STATUS, 8'h10);
    cyc(3);
    check({7'h00, irq}, 8'h00);
    wr(acd_pkg::ADDR_AB_CFG, 8'hba);
    cyc(8);
    rd(acd_pkg::ADDR_STATUS, 8'h11);
    wr(acd_pkg::ADDR_STATUS, 8'hf0);
    wr(acd_pkg::ADDR_AB_CFG, 8'h3a);
    cyc(8);
    rd(acd_pkg::ADDR_STATUS, 8'h00);
    wr(acd_pkg::ADDR_AB_CFG, 8'h8a);
    ain[0] <= 8'hff;
    cyc(8);
    check({7'h00, irq}, 8'h00);
    rd(acd_pkg::ADDR_STATUS, 8'h11);
    ain <= {4{8'h40}};
    ext <= 8'h10;
    wr(acd_pkg::ADDR_VTH_ZERO, 8'hf0);
    wr(acd_pkg::ADDR_VTH_ONE, 8'h10);
    wr(acd_pkg::ADDR_AB_CFG, 8'hcc);
    wr(acd_pkg::ADDR_CD_CFG, 8'hcc);
    cyc(8);
    wr(acd_pkg::ADDR_STATUS, 8'hf0);
    cyc(2);
    rd(acd_pkg::ADDR_STATUS, 8'h0f);
    wr(acd_pkg::ADDR_AB_CFG, 8'h88);
    wr(acd_pkg::ADDR_CD_CFG, 8'h88);
    cyc(8);
    rd(acd_pkg::ADDR_STATUS, 8'hf0);
    wr(acd_pkg::ADDR_STATUS, 8'hf1);
    ain[0] <= 8'hff;
    cyc(10);
    rd(acd_pkg::ADDR_STATUS, 8'h00);
    cyc(14);
    rd(acd_pkg::ADDR_STATUS, 8'h11);
    // unused dac codes parked at zero
    wr(acd_pkg::ADDR_VTH_ZERO, 8'h00);
    wr(acd_pkg::ADDR_VTH_ONE, 8'h00);
    cyc(3);
    check(lvl0, 8'h00);
    check(lvl1, 8'h00);
    results();
  end
endmodule : testbench
